// ==== rtl/drss_sequencer.sv ====
// Behaviour
// - Up/down mode uses creep parameters as creep speeds
// - Creep speed above maximum becomes maximum
// - Select digits pick parameter or analog creep source
// - Changeover input picks creep 1 or 2
// - Maximum speed held within 250..12000, bounds speeds
// - Signed bias added to ramp output speed
// - Bias plus aux 2 above zero speed level keeps running
// - Aux speed 2 active on function 02, scaled
// - Speed clamped by limiter mode and levels
// - Upper/lower mode bounds speed by levels 1 and 2, pins it at level 2 when level 2 >= level 1
// - Individual limits: level 1 bounds the forward direction, level 2 the reverse one (zero prevents it)
// - Command source zero selects keypad, else terminals
// - Keypad force input overrides command source
// - Keypad forward, reverse and stop keys
// - Both terminal commands on count as off
// - Run state drops at zero speed level
// - Zero level above maximum uses maximum
// - Continue timer runs at zero speed setting
// - Run command during continue timer resumes running
// - DC brake for set time, then coast
// - Direction from command, speed sign, switch
// - Pre-excite input excites until run command
// - Run command starts timed automatic pre-excitation
// - Coast input ends operation immediately
// - Coast works even while command hold latches
module drss_sequencer
	import drss_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic CORE_CLK_IN,
	input wire logic RESET_IN,
	input wire logic [15:0] MAX_SPEED_IN,
	input wire logic UPDOWN_MODE_IN,
	input wire logic signed [15:0] CREEP1_PARAM_IN,
	input wire logic signed [15:0] CREEP2_PARAM_IN,
	input wire logic [1:0] CREEP_SRC_SEL_IN,
	input wire logic signed [15:0] CREEP1_ANALOG_SOURCE_IN,
	input wire logic signed [15:0] CREEP2_ANALOG_SOURCE_IN,
	input wire logic CREEP_SELECT_INPUT_IN,
	input wire logic signed [15:0] ACC_DEC_SPEED_IN,
	input wire logic signed [15:0] SPEED_BIAS_IN,
	input wire logic [7:0] AI_FUNC_IN,
	input wire logic signed [15:0] AUX_SPEED_SETTING_2_IN,
	input wire logic [1:0] LIMIT_MODE_IN,
	input wire logic [10:0] LIMIT_LEVEL1_IN,
	input wire logic [10:0] LIMIT_LEVEL2_IN,
	input wire logic SPEED_LIMIT_INPUT_IN,
	input wire logic CMD_SOURCE_IN,
	input wire logic KEYPAD_FORCE_INPUT_IN,
	input wire logic KEY_FWD_IN,
	input wire logic KEY_REV_IN,
	input wire logic KEY_STOP_IN,
	input wire logic RUN_FORWARD_CMD_IN,
	input wire logic RUN_REVERSE_CMD_IN,
	input wire logic RUN_HOLD_INPUT_IN,
	input wire logic [15:0] ZERO_LEVEL_IN,
	input wire logic signed [15:0] MOTOR_SPEED_IN,
	input wire logic [10:0] CONTINUE_TIME_IN,
	input wire logic [10:0] DCB_TIME_IN,
	input wire logic [6:0] DCB_LEVEL_IN,
	input wire logic DIR_SWITCH_IN,
	input wire logic PREEXCITE_INPUT_IN,
	input wire logic [10:0] PREEXCITE_TIME_IN,
	input wire logic COAST_STOP_INPUT_IN,
	output logic signed [15:0] CREEP_SPEED_OUT,
	output logic signed [15:0] SPEED_CMD_OUT,
	output logic DIR_REVERSE_OUT,
	output logic RUN_ACTIVE_OUT,
	output logic DRIVE_ENABLE_OUT,
	output logic PREEXCITE_OUT,
	output logic DCB_ACTIVE_OUT,
	output logic [6:0] DCB_LEVEL_OUT
);

	localparam int PRESC_W = $clog2(TICK_CYCLES + 1);
	localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);

	function automatic logic signed [17:0] clamp_sym(input logic signed [17:0] v,
			input logic signed [17:0] m);
		if (v > m) begin
			return m;
		end
		if (v < -m) begin
			return -m;
		end
		return v;
	endfunction

	function automatic logic signed [17:0] scale_ai(input logic signed [15:0] ai,
			input logic [15:0] mx);
		logic signed [33:0] p;
		p = 34'(ai) * 34'(signed'({2'b00, mx}));
		return 18'(p >>> ANALOG_FS_SHIFT);
	endfunction

	function automatic logic signed [17:0] level_speed(input logic [10:0] lvl,
			input logic [15:0] mx);
		logic [10:0] l;
		logic [26:0] p;
		l = (lvl > LIMIT_LEVEL_MAX) ? LIMIT_LEVEL_MAX : lvl;
		p = 27'(mx) * 27'(l);
		return signed'(18'(p / LIMIT_SCALE));
	endfunction

	// Parameter conditioning
	logic [15:0] max_eff;
	logic [15:0] zero_eff;
	logic signed [17:0] max_s;
	logic signed [17:0] zero_s;
	logic [10:0] cont_t;
	logic [10:0] dcb_t;
	logic [10:0] preex_t;
	logic [6:0] dcb_lvl;

	always_comb begin
		if (MAX_SPEED_IN < MAX_SPEED_MIN) begin
			max_eff = MAX_SPEED_MIN;
		end else if (MAX_SPEED_IN > MAX_SPEED_MAX) begin
			max_eff = MAX_SPEED_MAX;
		end else begin
			max_eff = MAX_SPEED_IN;
		end
		if (ZERO_LEVEL_IN < ZERO_LEVEL_MIN) begin
			zero_eff = ZERO_LEVEL_MIN;
		end else if (ZERO_LEVEL_IN > ZERO_LEVEL_MAX) begin
			zero_eff = ZERO_LEVEL_MAX;
		end else begin
			zero_eff = ZERO_LEVEL_IN;
		end
		if (zero_eff > max_eff) begin
			zero_eff = max_eff;
		end
		cont_t = (CONTINUE_TIME_IN > CONT_TIME_MAX) ? CONT_TIME_MAX : CONTINUE_TIME_IN;
		dcb_t = (DCB_TIME_IN > DCB_TIME_MAX) ? DCB_TIME_MAX : DCB_TIME_IN;
		preex_t = (PREEXCITE_TIME_IN > PREEX_TIME_MAX) ? PREEX_TIME_MAX : PREEXCITE_TIME_IN;
		if (DCB_LEVEL_IN < DCB_LEVEL_MIN) begin
			dcb_lvl = DCB_LEVEL_MIN;
		end else if (DCB_LEVEL_IN > DCB_LEVEL_MAX) begin
			dcb_lvl = DCB_LEVEL_MAX;
		end else begin
			dcb_lvl = DCB_LEVEL_IN;
		end
	end

	assign max_s = signed'({2'b00, max_eff});
	assign zero_s = signed'({2'b00, zero_eff});

	// Creep speed selection
	logic signed [17:0] creep1;
	logic signed [17:0] creep2;
	logic signed [15:0] creep_nxt;
	logic signed [15:0] creep_r;

	always_comb begin
		creep1 = CREEP_SRC_SEL_IN[1] ? scale_ai(CREEP1_ANALOG_SOURCE_IN, max_eff) :
			18'(CREEP1_PARAM_IN);
		creep2 = CREEP_SRC_SEL_IN[0] ? scale_ai(CREEP2_ANALOG_SOURCE_IN, max_eff) :
			18'(CREEP2_PARAM_IN);
		creep_nxt = '0;
		if (UPDOWN_MODE_IN) begin
			creep_nxt = 16'(clamp_sym(CREEP_SELECT_INPUT_IN ? creep2 : creep1,
				max_s));
		end
	end

	// Speed setting path
	logic signed [17:0] aux2;
	logic signed [17:0] sustain_sum;
	logic sustain;
	logic signed [17:0] base_spd;
	logic signed [17:0] lv1;
	logic signed [17:0] lv2;
	logic signed [17:0] up_lim;
	logic signed [17:0] lo_lim;
	logic signed [17:0] limited;
	logic dir_cmd_rev_r;

	always_comb begin
		aux2 = (AI_FUNC_IN == AI_FUNC_AUX2) ?
			clamp_sym(scale_ai(AUX_SPEED_SETTING_2_IN, max_eff), max_s) : '0;
		sustain_sum = 18'(SPEED_BIAS_IN) + aux2;
		sustain = sustain_sum > zero_s;
		base_spd = clamp_sym(18'(ACC_DEC_SPEED_IN) + sustain_sum, max_s);
		lv1 = level_speed(LIMIT_LEVEL1_IN, max_eff);
		lv2 = level_speed(LIMIT_LEVEL2_IN, max_eff);
		up_lim = max_s;
		lo_lim = -max_s;
		if (SPEED_LIMIT_INPUT_IN) begin
			if (LIMIT_MODE_IN == LIM_MODE_FWDREV) begin
				up_lim = dir_cmd_rev_r ? lv2 : lv1;
				lo_lim = dir_cmd_rev_r ? -lv1 : -lv2;
			end else if (LIMIT_MODE_IN == LIM_MODE_UPLOW) begin
				up_lim = lv1;
				lo_lim = lv2;
			end
		end
		// Lower limit applied last so it wins when the levels cross
		limited = (base_spd > up_lim) ? up_lim : base_spd;
		limited = (limited < lo_lim) ? lo_lim : limited;
	end

	// Run command resolution
	logic keypad_mode;
	logic key_fwd_r;
	logic key_rev_r;
	logic key_fwd_nxt;
	logic key_rev_nxt;
	logic live_fwd;
	logic live_rev;
	logic held_fwd_r;
	logic held_rev_r;
	logic held_fwd_nxt;
	logic held_rev_nxt;
	logic cmd_fwd;
	logic cmd_rev;
	logic cmd_any;
	logic run_req;
	logic dir_cmd_rev_nxt;

	assign keypad_mode = (CMD_SOURCE_IN == CMD_SRC_KEYPAD) ||
		KEYPAD_FORCE_INPUT_IN;

	always_comb begin
		key_fwd_nxt = key_fwd_r;
		key_rev_nxt = key_rev_r;
		if (!keypad_mode || KEY_STOP_IN || COAST_STOP_INPUT_IN) begin
			key_fwd_nxt = 1'b0;
			key_rev_nxt = 1'b0;
		end else if (KEY_FWD_IN) begin
			key_fwd_nxt = 1'b1;
			key_rev_nxt = 1'b0;
		end else if (KEY_REV_IN) begin
			key_fwd_nxt = 1'b0;
			key_rev_nxt = 1'b1;
		end
		if (keypad_mode) begin
			live_fwd = key_fwd_r;
			live_rev = key_rev_r;
		end else begin
			live_fwd = RUN_FORWARD_CMD_IN && !RUN_REVERSE_CMD_IN;
			live_rev = RUN_REVERSE_CMD_IN && !RUN_FORWARD_CMD_IN;
		end
		// Hold freezes the command, but coast still clears it
		if (COAST_STOP_INPUT_IN) begin
			held_fwd_nxt = 1'b0;
			held_rev_nxt = 1'b0;
		end else if (RUN_HOLD_INPUT_IN) begin
			held_fwd_nxt = held_fwd_r;
			held_rev_nxt = held_rev_r;
		end else begin
			held_fwd_nxt = live_fwd;
			held_rev_nxt = live_rev;
		end
		cmd_fwd = RUN_HOLD_INPUT_IN ? held_fwd_r : live_fwd;
		cmd_rev = RUN_HOLD_INPUT_IN ? held_rev_r : live_rev;
		cmd_any = cmd_fwd || cmd_rev;
		run_req = cmd_any || sustain;
		dir_cmd_rev_nxt = cmd_fwd ? 1'b0 : (cmd_rev ? 1'b1 : dir_cmd_rev_r);
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			key_fwd_r <= 1'b0;
			key_rev_r <= 1'b0;
			held_fwd_r <= 1'b0;
			held_rev_r <= 1'b0;
			dir_cmd_rev_r <= 1'b0;
		end else begin
			key_fwd_r <= key_fwd_nxt;
			key_rev_r <= key_rev_nxt;
			held_fwd_r <= held_fwd_nxt;
			held_rev_r <= held_rev_nxt;
			dir_cmd_rev_r <= dir_cmd_rev_nxt;
		end
	end

	// Sequencer with shared tick timer
	drss_state_e state_r;
	drss_state_e state_nxt;
	drss_state_e stop_state;
	logic [PRESC_W-1:0] presc_r;
	logic [PRESC_W-1:0] presc_nxt;
	logic [TIME_W-1:0] timer_r;
	logic [TIME_W-1:0] timer_nxt;
	logic [TIME_W-1:0] stop_time;
	logic tick;
	logic timer_done;
	logic at_zero;
	logic load;
	logic [15:0] motor_abs;
	logic signed [15:0] speed_nxt;
	logic signed [15:0] speed_r;
	logic dir_nxt;
	logic dir_r;
	logic [6:0] dcb_lvl_nxt;
	logic [6:0] dcb_lvl_r;

	assign tick = presc_r == PRESC_LAST;
	assign timer_done = timer_r == '0;
	assign motor_abs = MOTOR_SPEED_IN[15] ? 16'(-MOTOR_SPEED_IN) : MOTOR_SPEED_IN;
	assign at_zero = motor_abs <= zero_eff;

	always_comb begin
		if (cont_t != '0) begin
			stop_state = ST_CONTINUE;
			stop_time = cont_t;
		end else if (dcb_t != '0) begin
			stop_state = ST_DCBRAKE;
			stop_time = dcb_t;
		end else begin
			stop_state = ST_IDLE;
			stop_time = '0;
		end
	end

	always_comb begin
		state_nxt = state_r;
		load = 1'b0;
		timer_nxt = (tick && !timer_done) ? timer_r - 1'b1 : timer_r;
		if (COAST_STOP_INPUT_IN) begin
			state_nxt = ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (cmd_any && preex_t != '0) begin
						state_nxt = ST_PREEX_AUTO;
						timer_nxt = preex_t;
						load = 1'b1;
					end else if (run_req) begin
						state_nxt = ST_RUN;
					end else if (PREEXCITE_INPUT_IN) begin
						state_nxt = ST_PREEX_MAN;
					end
				end
				ST_PREEX_MAN: begin
					if (cmd_any) begin
						state_nxt = ST_RUN;
					end else if (!PREEXCITE_INPUT_IN) begin
						state_nxt = ST_IDLE;
					end
				end
				ST_PREEX_AUTO: begin
					if (!cmd_any) begin
						state_nxt = ST_IDLE;
					end else if (timer_done) begin
						state_nxt = ST_RUN;
					end
				end
				ST_RUN: begin
					if (!run_req) begin
						state_nxt = ST_DECEL;
					end
				end
				ST_DECEL: begin
					if (run_req) begin
						state_nxt = ST_RUN;
					end else if (at_zero) begin
						state_nxt = stop_state;
						timer_nxt = stop_time;
						load = 1'b1;
					end
				end
				ST_CONTINUE: begin
					if (cmd_any) begin
						state_nxt = ST_RUN;
					end else if (timer_done) begin
						state_nxt = (dcb_t != '0) ? ST_DCBRAKE : ST_IDLE;
						timer_nxt = dcb_t;
						load = 1'b1;
					end
				end
				ST_DCBRAKE: begin
					// No stop check here; an unstopped motor coasts
					if (timer_done) begin
						state_nxt = ST_IDLE;
					end
				end
			endcase
		end
		// Restart the prescaler on load so an interval is never short
		presc_nxt = (load || tick) ? '0 : presc_r + 1'b1;
		speed_nxt = '0;
		if (state_r == ST_RUN || state_r == ST_DECEL) begin
			speed_nxt = 16'(limited);
		end
		dir_nxt = dir_cmd_rev_r ^ limited[17] ^ DIR_SWITCH_IN;
		dcb_lvl_nxt = (state_nxt == ST_DCBRAKE) ? dcb_lvl : '0;
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			state_r <= ST_IDLE;
			presc_r <= '0;
			timer_r <= '0;
			creep_r <= '0;
			speed_r <= '0;
			dir_r <= 1'b0;
			dcb_lvl_r <= '0;
		end else begin
			state_r <= state_nxt;
			presc_r <= presc_nxt;
			timer_r <= timer_nxt;
			creep_r <= creep_nxt;
			speed_r <= speed_nxt;
			dir_r <= dir_nxt;
			dcb_lvl_r <= dcb_lvl_nxt;
		end
	end

	assign CREEP_SPEED_OUT = creep_r;
	assign SPEED_CMD_OUT = speed_r;
	assign DIR_REVERSE_OUT = dir_r;
	assign RUN_ACTIVE_OUT = (state_r == ST_RUN) || (state_r == ST_DECEL);
	assign DRIVE_ENABLE_OUT = (state_r != ST_IDLE) && (state_r != ST_DCBRAKE);
	assign PREEXCITE_OUT = (state_r == ST_PREEX_MAN) || (state_r == ST_PREEX_AUTO);
	assign DCB_ACTIVE_OUT = state_r == ST_DCBRAKE;
	assign DCB_LEVEL_OUT = dcb_lvl_r;

	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (RESET_IN);

	property p_coast;
		COAST_STOP_INPUT_IN |=> !DRIVE_ENABLE_OUT && !RUN_ACTIVE_OUT && !DCB_ACTIVE_OUT;
	endproperty
	a_coast: assert property (p_coast) else $error("coast did not remove drive");

	property p_hold_coast;
		RUN_HOLD_INPUT_IN && COAST_STOP_INPUT_IN |=> !held_fwd_r && !held_rev_r;
	endproperty
	a_hold_coast: assert property (p_hold_coast) else $error("hold survived coast");

	property p_creep_clamp;
		1'b1 |=> (18'(CREEP_SPEED_OUT) <= $past(max_s)) && (18'(CREEP_SPEED_OUT) >= -$past(max_s));
	endproperty
	a_creep_clamp: assert property (p_creep_clamp) else $error("creep above maximum");

	property p_term_both;
		!keypad_mode && RUN_FORWARD_CMD_IN && RUN_REVERSE_CMD_IN |-> !live_fwd && !live_rev;
	endproperty
	a_term_both: assert property (p_term_both) else $error("both terminals accepted");

	property p_key_stop;
		keypad_mode && KEY_STOP_IN |=> !key_fwd_r && !key_rev_r;
	endproperty
	a_key_stop: assert property (p_key_stop) else $error("stop key ignored");

	property p_zero_stop;
		state_r == ST_DECEL && at_zero && !run_req |=> !RUN_ACTIVE_OUT;
	endproperty
	a_zero_stop: assert property (p_zero_stop) else $error("run kept at zero speed");

	property p_cont_resume;
		state_r == ST_CONTINUE && cmd_any && !COAST_STOP_INPUT_IN |=> state_r == ST_RUN;
	endproperty
	a_cont_resume: assert property (p_cont_resume) else $error("no resume in continue");

	property p_cont_zero;
		// Drive is checked in the state itself; the next state may be brake or idle
		state_r == ST_CONTINUE |-> DRIVE_ENABLE_OUT ##1 SPEED_CMD_OUT == 16'sh0000;
	endproperty
	a_cont_zero: assert property (p_cont_zero) else $error("continue speed not zero");

	property p_limit_l2;
		state_r == ST_RUN && LIMIT_MODE_IN == LIM_MODE_UPLOW && SPEED_LIMIT_INPUT_IN && lv2 >= lv1
			|=> SPEED_CMD_OUT == 16'($past(lv2));
	endproperty
	a_limit_l2: assert property (p_limit_l2) else $error("speed not held at level 2");

	property p_auto_preex;
		state_r == ST_IDLE && cmd_any && !COAST_STOP_INPUT_IN && preex_t != '0
			|=> PREEXCITE_OUT ##1 (PREEXCITE_OUT || RUN_ACTIVE_OUT || !DRIVE_ENABLE_OUT);
	endproperty
	a_auto_preex: assert property (p_auto_preex) else $error("no auto pre-excitation");

	c_continue: cover property (state_r == ST_DECEL ##1 state_r == ST_CONTINUE);
	c_dcbrake: cover property (state_r == ST_DCBRAKE ##1 state_r == ST_IDLE);
	c_preex_run: cover property (state_r == ST_PREEX_AUTO ##1 state_r == ST_RUN);
	c_coast_run: cover property (state_r == ST_RUN ##1 state_r == ST_IDLE);

endmodule // drss_sequencer

// ==== shared/drss_pkg.sv ====
package drss_pkg;

	localparam int SPD_W = 16;
	localparam int SUM_W = 18;

	// Maximum speed bounds, r/min
	localparam logic [15:0] MAX_SPEED_MIN = 16'h00fa;
	localparam logic [15:0] MAX_SPEED_MAX = 16'h2ee0;
	// Zero speed detection level bounds, r/min
	localparam logic [15:0] ZERO_LEVEL_MIN = 16'h0001;
	localparam logic [15:0] ZERO_LEVEL_MAX = 16'h04b0;
	// Limiter levels in 0.1 percent of maximum speed
	localparam logic [10:0] LIMIT_LEVEL_MAX = 11'h44c;
	localparam logic [26:0] LIMIT_SCALE = 27'h00003e8;
	// Analog input: 10 V reads as 2**14 counts
	localparam int ANALOG_FS_SHIFT = 14;
	localparam logic [7:0] AI_FUNC_AUX2 = 8'h02;

	localparam logic [1:0] LIM_MODE_OFF = 2'h0;
	localparam logic [1:0] LIM_MODE_FWDREV = 2'h1;
	localparam logic [1:0] LIM_MODE_UPLOW = 2'h2;
	localparam logic CMD_SRC_KEYPAD = 1'b0;

	// Timed intervals, counted in 10 ms ticks
	localparam int TIME_W = 11;
	localparam logic [10:0] CONT_TIME_MAX = 11'h1f4;
	localparam logic [10:0] DCB_TIME_MAX = 11'h3e8;
	localparam logic [10:0] PREEX_TIME_MAX = 11'h3e8;
	localparam logic [6:0] DCB_LEVEL_MIN = 7'h0a;
	localparam logic [6:0] DCB_LEVEL_MAX = 7'h64;

	localparam int TICK_PERIOD_NS = 10000000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PREEX_MAN,
		ST_PREEX_AUTO,
		ST_RUN,
		ST_DECEL,
		ST_CONTINUE,
		ST_DCBRAKE
	} drss_state_e;

endpackage

// ==== dv/drss_motor_model.sv ====
module drss_motor_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic slow_in,
	input wire logic drive_in,
	input wire logic signed [15:0] cmd_in,
	output logic signed [15:0] speed_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic signed [15:0] speed_r, speed_nxt, tgt, stp;
	// Undriven motor drifts to rest; slow mode lingers near the zero band
	always_comb begin
		tgt = drive_in ? cmd_in : 16'sh0000;
		stp = slow_in ? 16'sh000a : 16'sh0032;
		speed_nxt = tgt;
		if (tgt > speed_r + stp) begin
			speed_nxt = speed_r + stp;
		end else if (tgt < speed_r - stp) begin
			speed_nxt = speed_r - stp;
		end
	end
	always_ff @(posedge clk_in) begin
		speed_r <= rst_in ? 16'sh0000 : speed_nxt;
	end
	assign speed_out = speed_r;
endmodule // drss_motor_model

// ==== dv/drss_sequencer_tb.sv ====
module drss_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] max_spd, zlvl;
	logic signed [15:0] c1p, c2p, c1a, c2a, acc, bias, aux2, mspd, spd, crp;
	logic updn, csel, lim_in, src, fkp, kf, kr, ks, run_forward_cmd, run_reverse_cmd, hold, dsw, pre, coast, slow;
	logic [1:0] srcsel, lmode;
	logic [7:0] aif;
	logic [10:0] l1, l2, ctime, dtime, ptime;
	logic [6:0] dlvl, dlvl_o;
	logic dir, run, drv, pex, dcb;
	wire [3:0] fl = {run, drv, pex, dcb};
	typedef struct {logic [15:0] spd; logic [15:0] crp; logic [3:0] fl; logic dir; logic ms;} drss_exp_s;
	drss_exp_s q[$];
	drss_exp_s e;
	event chk_ev;
	int fails = 0;
	int cmp_count = 0;
	int n;

	always #2.5 clk = ~clk;

	drss_sequencer #(.TICK_CYCLES(4)) u_drss_sequencer (
		.CORE_CLK_IN(clk), .RESET_IN(rst), .MAX_SPEED_IN(max_spd), .UPDOWN_MODE_IN(updn),
		.CREEP1_PARAM_IN(c1p), .CREEP2_PARAM_IN(c2p), .CREEP_SRC_SEL_IN(srcsel),
		.CREEP1_ANALOG_SOURCE_IN(c1a), .CREEP2_ANALOG_SOURCE_IN(c2a),
		.CREEP_SELECT_INPUT_IN(csel), .ACC_DEC_SPEED_IN(acc), .SPEED_BIAS_IN(bias),
		.AI_FUNC_IN(aif), .AUX_SPEED_SETTING_2_IN(aux2), .LIMIT_MODE_IN(lmode),
		.LIMIT_LEVEL1_IN(l1), .LIMIT_LEVEL2_IN(l2), .SPEED_LIMIT_INPUT_IN(lim_in),
		.CMD_SOURCE_IN(src), .KEYPAD_FORCE_INPUT_IN(fkp), .KEY_FWD_IN(kf), .KEY_REV_IN(kr),
		.KEY_STOP_IN(ks), .RUN_FORWARD_CMD_IN(run_forward_cmd), .RUN_REVERSE_CMD_IN(run_reverse_cmd),
		.RUN_HOLD_INPUT_IN(hold), .ZERO_LEVEL_IN(zlvl), .MOTOR_SPEED_IN(mspd),
		.CONTINUE_TIME_IN(ctime), .DCB_TIME_IN(dtime), .DCB_LEVEL_IN(dlvl),
		.DIR_SWITCH_IN(dsw), .PREEXCITE_INPUT_IN(pre), .PREEXCITE_TIME_IN(ptime),
		.COAST_STOP_INPUT_IN(coast), .CREEP_SPEED_OUT(crp), .SPEED_CMD_OUT(spd),
		.DIR_REVERSE_OUT(dir), .RUN_ACTIVE_OUT(run), .DRIVE_ENABLE_OUT(drv),
		.PREEXCITE_OUT(pex), .DCB_ACTIVE_OUT(dcb), .DCB_LEVEL_OUT(dlvl_o)
	);

	drss_motor_model u_drss_motor_model (
		.clk_in(clk), .rst_in(rst), .slow_in(slow), .drive_in(drv), .cmd_in(spd),
		.speed_out(mspd)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial forever begin
		@(chk_ev);
		e = q.pop_front();
		if (e.ms) check(spd, e.spd, "speed command");
		check(crp, e.crp, "creep speed");
		check({12'h000, fl}, {12'h000, e.fl}, "state flags");
		check({15'h0000, dir}, {15'h0000, e.dir}, "direction");
	end

	task automatic expect_st(input int s, input int c, input logic [3:0] f, input logic d,
			input logic m);
		q.push_back('{s[15:0], c[15:0], f, d, m});
		->chk_ev;
	endtask

	task automatic step(input int k);
		repeat (k) @(negedge clk);
	endtask

	// Bounded waits: a stuck state shows as a mismatch, not a hang
	task automatic wait_fl(input logic [3:0] p);
		n = 0;
		while (fl !== p && n < 3000) begin
			step(1);
			n++;
		end
		check({15'h0000, n < 3000}, 16'h0001, "state not reached");
	endtask

	task automatic span(input logic [3:0] p, input int lo, input int hi);
		n = 0;
		while (fl === p && n < 3000) begin
			step(1);
			n++;
		end
		check({15'h0000, n >= lo && n <= hi}, 16'h0001, "interval length");
	endtask

	task automatic go_idle();
		run_forward_cmd = 1'b0;
		run_reverse_cmd = 1'b0;
		acc = 16'sh0000;
		bias = 16'sh0000;
		wait_fl(4'b0000);
	endtask

	initial begin
		#200000;
		fails++;
		tally_and_finish();
	end

	initial begin
		{updn, csel, lim_in, fkp, kf, kr, ks, run_forward_cmd, run_reverse_cmd, hold, dsw, pre, coast, slow} = '0;
		{srcsel, lmode, aif, l1, l2, ctime, dtime, ptime} = '0;
		{c1p, c2p, c1a, c2a, acc, bias, aux2} = '0;
		max_spd = 16'h0bb8;
		zlvl = 16'h001e;
		dlvl = 7'h32;
		src = 1'b1;
		void'($urandom(32'h0e5dbcf3));
		step(16);
		rst = 1'b0;
		step(1);
		for (int i = 0; i < 8; i++) begin
			bias = 16'($urandom_range(200, 0));
			acc = 16'($urandom_range(2000, 300));
			if (i[1]) acc = -acc;
			dsw = i[0];
			run_forward_cmd = !i[2];
			run_reverse_cmd = i[2];
			step(3);
			expect_st(acc + bias, 0, 4'b1100, ^i[2:0], 1'b1);
			go_idle();
		end
		// Last loop pass left reverse latched; switch set keeps idle direction forward
		run_forward_cmd = 1'b1;
		run_reverse_cmd = 1'b1;
		step(3);
		expect_st(0, 0, 4'b0000, 1'b0, 1'b1);
		run_forward_cmd = 1'b0;
		run_reverse_cmd = 1'b0;
		src = 1'b0;
		acc = 16'sd700;
		run_forward_cmd = 1'b1;
		step(3);
		expect_st(0, 0, 4'b0000, 1'b0, 1'b1);
		run_forward_cmd = 1'b0;
		dsw = 1'b0;
		kr = 1'b1;
		step(1);
		kr = 1'b0;
		step(2);
		expect_st(700, 0, 4'b1100, 1'b1, 1'b1);
		ks = 1'b1;
		step(1);
		ks = 1'b0;
		acc = 16'sh0000;
		wait_fl(4'b0000);
		src = 1'b1;
		fkp = 1'b1;
		acc = 16'sd900;
		kf = 1'b1;
		step(1);
		kf = 1'b0;
		step(2);
		expect_st(900, 0, 4'b1100, 1'b0, 1'b1);
		ks = 1'b1;
		step(1);
		ks = 1'b0;
		go_idle();
		fkp = 1'b0;
		ctime = 11'd3;
		dtime = 11'd2;
		dlvl = 7'd5;
		slow = 1'b1;
		acc = 16'sd600;
		run_forward_cmd = 1'b1;
		step(3);
		run_forward_cmd = 1'b0;
		acc = 16'sh0000;
		wait_fl(4'b0100);
		check({15'h0000, mspd <= 30 && mspd >= -30}, 16'h0001, "stopped early");
		check(spd, 16'h0000, "continue speed");
		span(4'b0100, 12, 14);
		check({9'h000, dlvl_o}, 16'h000a, "brake level");
		expect_st(0, 0, 4'b0001, 1'b0, 1'b1);
		span(4'b0001, 8, 10);
		expect_st(0, 0, 4'b0000, 1'b0, 1'b1);
		dtime = 11'd0;
		acc = 16'sd600;
		run_forward_cmd = 1'b1;
		step(3);
		run_forward_cmd = 1'b0;
		acc = 16'sh0000;
		wait_fl(4'b0100);
		step(2);
		run_forward_cmd = 1'b1;
		acc = 16'sd600;
		step(2);
		expect_st(600, 0, 4'b1100, 1'b0, 1'b1);
		go_idle();
		ctime = 11'd0;
		slow = 1'b0;
		acc = 16'sd500;
		run_forward_cmd = 1'b1;
		step(3);
		hold = 1'b1;
		step(1);
		coast = 1'b1;
		step(1);
		expect_st(0, 0, 4'b0000, 1'b0, 1'b0);
		run_forward_cmd = 1'b0;
		hold = 1'b0;
		step(1);
		coast = 1'b0;
		step(2);
		expect_st(0, 0, 4'b0000, 1'b0, 1'b1);
		pre = 1'b1;
		step(2);
		expect_st(0, 0, 4'b0110, 1'b0, 1'b1);
		acc = 16'sd400;
		run_forward_cmd = 1'b1;
		pre = 1'b0;
		step(3);
		expect_st(400, 0, 4'b1100, 1'b0, 1'b1);
		go_idle();
		ptime = 11'd2;
		acc = 16'sd400;
		run_forward_cmd = 1'b1;
		wait_fl(4'b0110);
		span(4'b0110, 8, 10);
		step(1);
		expect_st(400, 0, 4'b1100, 1'b0, 1'b1);
		ptime = 11'd0;
		acc = 16'sd100;
		lmode = 2'd2;
		l1 = 11'd500;
		l2 = 11'd600;
		lim_in = 1'b1;
		step(3);
		expect_st(1800, 0, 4'b1100, 1'b0, 1'b1);
		lim_in = 1'b0;
		step(3);
		expect_st(100, 0, 4'b1100, 1'b0, 1'b1);
		lmode = 2'd1;
		lim_in = 1'b1;
		l1 = 11'd1000;
		l2 = 11'd0;
		acc = -16'sd800;
		step(3);
		expect_st(0, 0, 4'b1100, 1'b0, 1'b1);
		acc = 16'sd2000;
		step(3);
		expect_st(2000, 0, 4'b1100, 1'b0, 1'b1);
		go_idle();
		run_reverse_cmd = 1'b1;
		acc = 16'sd800;
		step(3);
		expect_st(0, 0, 4'b1100, 1'b1, 1'b1);
		acc = -16'sd800;
		step(3);
		expect_st(-800, 0, 4'b1100, 1'b0, 1'b1);
		go_idle();
		// Reverse stays latched after stop; switch inverts it back to forward
		dsw = 1'b1;
		lmode = 2'd0;
		lim_in = 1'b0;
		bias = 16'sd100;
		aif = 8'h02;
		aux2 = 16'sd8192;
		step(3);
		expect_st(1600, 0, 4'b1100, 1'b0, 1'b1);
		bias = 16'sh0000;
		aux2 = 16'sh4000;
		step(3);
		expect_st(3000, 0, 4'b1100, 1'b0, 1'b1);
		aif = 8'h01;
		bias = 16'sd20;
		wait_fl(4'b0000);
		{aif, bias, aux2} = '0;
		updn = 1'b1;
		c1p = 16'sd5000;
		c2p = 16'sd700;
		step(3);
		expect_st(0, 3000, 4'b0000, 1'b0, 1'b1);
		csel = 1'b1;
		step(3);
		expect_st(0, 700, 4'b0000, 1'b0, 1'b1);
		srcsel = 2'b01;
		c2a = 16'sd8192;
		step(3);
		expect_st(0, 1500, 4'b0000, 1'b0, 1'b1);
		srcsel = 2'b10;
		csel = 1'b0;
		c1a = 16'sh4000;
		step(3);
		expect_st(0, 3000, 4'b0000, 1'b0, 1'b1);
		srcsel = 2'b00;
		max_spd = 16'd100;
		c1p = 16'sd1000;
		step(3);
		expect_st(0, 250, 4'b0000, 1'b0, 1'b1);
		max_spd = 16'd13000;
		c1p = 16'sd12500;
		step(3);
		expect_st(0, 12000, 4'b0000, 1'b0, 1'b1);
		updn = 1'b0;
		step(3);
		expect_st(0, 0, 4'b0000, 1'b0, 1'b1);
		step(2);
		tally_and_finish();
	end
endmodule // drss_sequencer_tb
